// ### verilog/pwmdac_map.svh
// Behaviour
// - 14-bit code sets pulse-divided PWM duty
// - lower three data registers write-only, read as zero
// - top write commits whole code; lower writes don't
// - waveform runs on internal clock after latching
// - frame split into 64 sub-frames, low spread
// - frame low time equals min(code + 64, 16384) half-cycles
// - frame 8192 cycles, sub-frame 128 cycles
// - first register carries code bits 3 to 0
`ifndef PWMDAC_MAP_SVH
`define PWMDAC_MAP_SVH

// ----------------------------------------------------------------
// register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PWMDAC_IDX_NIB0     6'h16
`define PWMDAC_IDX_NIB1     6'h17
`define PWMDAC_IDX_NIB2     6'h18
`define PWMDAC_IDX_TOP      6'h19
`define PWMDAC_IDX_STATUS   6'h1a

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define PWMDAC_NIB_LSB      0
`define PWMDAC_NIB_MSB      3
`define PWMDAC_TOP_MSB      1
`define PWMDAC_STAT_ACTIVE  0
`define PWMDAC_STAT_PENDING 1
`define PWMDAC_STAT_LEVEL   2
`define PWMDAC_NIB_RST      4'h0
`define PWMDAC_CODE_RST     14'h0000
`define PWMDAC_RDATA_RST    32'h0000_0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PWMDAC_CLK_PS       4000
`define PWMDAC_TCYC_PS      953600
`define PWMDAC_HALF_DIV     (`PWMDAC_TCYC_PS / (2 * `PWMDAC_CLK_PS))
`define PWMDAC_SUBFRAMES    64
`define PWMDAC_SUB_TICKS    256
`define PWMDAC_FRAME_TICKS  16384
`define PWMDAC_LOW_OFFSET   64
`define PWMDAC_FRAME_LAST   14'h3fff

`endif

// ### verilog/pwmdac_pkg.sv
`default_nettype none
package pwmdac_pkg;
    typedef logic [13:0] pwmdac_code_t;
    typedef logic [3:0]  pwmdac_nib_t;
    typedef logic [1:0]  pwmdac_resp_t;
    typedef logic [31:0] pwmdac_data_t;
    typedef logic [7:0]  pwmdac_addr_t;
    typedef logic [3:0]  pwmdac_strb_t;
    typedef logic [2:0]  pwmdac_prot_t;
    typedef enum logic [1:0] {
        PWMDAC_OKAY   = 2'h0,
        PWMDAC_DECERR = 2'h3
    } pwmdac_axresp_t;
    typedef enum {
        PWMDAC_IDLE,
        PWMDAC_RUN
    } pwmdac_state_t;
endpackage
`default_nettype wire

// ### verilog/pwmdac_code_if.sv
`default_nettype none
interface pwmdac_code_if;
    import pwmdac_pkg::*;
    pwmdac_code_t code;
    logic         pending;
    logic         taken;
    logic         active;
    logic         level;
    modport ctl (output code, output pending,
                 input taken, input active, input level);
    modport mod (input code, input pending,
                 output taken, output active, output level);
endinterface
`default_nettype wire

// ### verilog/pwmdac_mod.sv
`include "pwmdac_map.svh"
`default_nettype none
module pwmdac_mod #(
    parameter int unsigned HALF_DIV = `PWMDAC_HALF_DIV
) (
    input  wire logic      aclk,
    input  wire logic      aresetn,
    pwmdac_code_if.mod     cif,
    output var  logic      pin
);
    import pwmdac_pkg::*;

    localparam int unsigned DIV_W = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;

    if (HALF_DIV < 1) begin
        $error("HALF_DIV must be at least 1");
    end

    pwmdac_state_t state;
    logic [DIV_W-1:0] div_cnt;
    logic [13:0]      pos;
    pwmdac_code_t     cur_code;
    logic             tick;
    logic             frame_end;
    logic             load;
    logic             extra;
    logic [8:0]       low_len;
    logic             low_now;

    function automatic logic [5:0] bitrev6(input logic [5:0] v);
        for (int i = 0; i < 6; i++) begin
            bitrev6[i] = v[5-i];
        end
    endfunction

    // ----------------------------------------------------------------
    // half-cycle tick and frame position
    // ----------------------------------------------------------------
    assign tick      = (div_cnt == DIV_W'(HALF_DIV - 1));
    assign frame_end = (state == PWMDAC_RUN) && tick &&
                       (pos == `PWMDAC_FRAME_LAST);
    assign load      = cif.pending &&
                       ((state == PWMDAC_IDLE) || frame_end);
    assign cif.taken  = load;
    assign cif.active = (state == PWMDAC_RUN);
    assign cif.level  = pin;

    always_ff @(posedge aclk) begin
        if (!aresetn || state == PWMDAC_IDLE || tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + DIV_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= PWMDAC_IDLE;
        end else if (load) begin
            state <= PWMDAC_RUN;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || state == PWMDAC_IDLE) begin
            pos <= '0;
        end else if (tick) begin
            pos <= pos + 14'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_code <= `PWMDAC_CODE_RST;
        end else if (load) begin
            cur_code <= cif.code;
        end
    end

    // ----------------------------------------------------------------
    // low time: base of code[13:6]+1 per sub-frame, remainder spread
    // ----------------------------------------------------------------
    assign extra   = (bitrev6(pos[13:8]) < cur_code[5:0]);
    assign low_len = {1'b0, cur_code[13:6]} + 9'h001 +
                     {8'h00, extra};
    assign low_now = (state == PWMDAC_RUN) &&
                     ({1'b0, pos[7:0]} < low_len);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin <= 1'b1;
        end else begin
            pin <= !low_now;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [14:0] low_acc;
    int unsigned frame_clk;
    logic [14:0] low_total;
    logic [14:0] low_expect;

    always_ff @(posedge aclk) begin
        if (!aresetn || state == PWMDAC_IDLE || frame_end) begin
            low_acc <= '0;
        end else if (tick && low_now) begin
            low_acc <= low_acc + 15'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || state == PWMDAC_IDLE || frame_end) begin
            frame_clk <= 0;
        end else begin
            frame_clk <= frame_clk + 1;
        end
    end

    assign low_total  = low_acc + {14'h0000, low_now};
    assign low_expect = ({1'b0, cur_code} + 15'h0040 > 15'h4000) ?
                        15'h4000 : {1'b0, cur_code} + 15'h0040;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    frame_low_total_a: assert property (
        frame_end |-> low_total == low_expect)
        else $error("frame low time differs from code plus 64");
    frame_period_a: assert property (
        frame_end |-> frame_clk == 16384 * HALF_DIV - 1)
        else $error("frame is not 8192 instruction cycles");
    subframe_low_a: assert property (
        (state == PWMDAC_RUN && pos[7:0] == 8'h00) |-> low_now)
        else $error("sub-frame does not open with a low pulse");
    idle_high_a: assert property (
        (state == PWMDAC_IDLE) |=> pin)
        else $error("pin low before any code was latched");
    code_at_edge_a: assert property (
        $changed(cur_code) |-> $past(load))
        else $error("code changed away from a frame boundary");
    pin_follows_a: assert property (
        (state == PWMDAC_RUN) |=> pin == !$past(low_now))
        else $error("pin does not follow the low window");

    frame_done_c: cover property (frame_end);
    reload_c: cover property (frame_end && cif.pending);
    spread_c: cover property (tick && extra && pos[7:0] == low_len[7:0]);
endmodule
`default_nettype wire

// ### verilog/pwmdac_top.sv
// The AXI4-Lite slave port was chosen for this implementation.
`include "pwmdac_map.svh"
`default_nettype none
module pwmdac_top #(
    parameter int unsigned HALF_DIV = `PWMDAC_HALF_DIV,
    parameter int unsigned ADDR_W   = 8
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire pwmdac_pkg::pwmdac_addr_t awaddr,
    input  wire pwmdac_pkg::pwmdac_prot_t awprot,
    input  wire logic                 awvalid,
    output var  logic                 awready,
    input  wire pwmdac_pkg::pwmdac_data_t wdata,
    input  wire pwmdac_pkg::pwmdac_strb_t wstrb,
    input  wire logic                 wvalid,
    output var  logic                 wready,
    output var  pwmdac_pkg::pwmdac_resp_t bresp,
    output var  logic                 bvalid,
    input  wire logic                 bready,
    input  wire pwmdac_pkg::pwmdac_addr_t araddr,
    input  wire pwmdac_pkg::pwmdac_prot_t arprot,
    input  wire logic                 arvalid,
    output var  logic                 arready,
    output var  pwmdac_pkg::pwmdac_data_t rdata,
    output var  pwmdac_pkg::pwmdac_resp_t rresp,
    output var  logic                 rvalid,
    input  wire logic                 rready,
    output var  logic                 shared_port_modulator_output_pin
);
    import pwmdac_pkg::*;

    if (ADDR_W != 8) begin
        $error("ADDR_W must be 8");
    end
    if (HALF_DIV < 1) begin
        $error("HALF_DIV must be at least 1");
    end

    pwmdac_code_if cif ();

    // ----------------------------------------------------------------
    // write channel capture
    // ----------------------------------------------------------------
    logic         aw_held;
    logic [5:0]   aw_idx;
    logic         w_held;
    pwmdac_data_t w_data;
    pwmdac_strb_t w_strb;
    logic         do_write;
    logic         wr_lane0;
    logic         wr_mapped;

    assign awready  = !aw_held;
    assign wready   = !w_held;
    assign do_write = aw_held && w_held && !bvalid;
    assign wr_lane0 = do_write && w_strb[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_idx  <= 6'h00;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_idx  <= awaddr[7:2];
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= `PWMDAC_RDATA_RST;
            w_strb <= 4'h0;
        end else if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_comb begin
        unique case (aw_idx)
            `PWMDAC_IDX_NIB0,
            `PWMDAC_IDX_NIB1,
            `PWMDAC_IDX_NIB2,
            `PWMDAC_IDX_TOP,
            `PWMDAC_IDX_STATUS: wr_mapped = 1'b1;
            default:            wr_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= PWMDAC_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= wr_mapped ? PWMDAC_OKAY : PWMDAC_DECERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // staged code nibbles and commit
    // ----------------------------------------------------------------
    pwmdac_nib_t  nib0;
    pwmdac_nib_t  nib1;
    pwmdac_nib_t  nib2;
    logic         commit;
    pwmdac_code_t staged;
    logic         pending;

    assign commit = wr_lane0 && (aw_idx == `PWMDAC_IDX_TOP);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nib0 <= `PWMDAC_NIB_RST;
        end else if (wr_lane0 && aw_idx == `PWMDAC_IDX_NIB0) begin
            nib0 <= w_data[`PWMDAC_NIB_MSB:`PWMDAC_NIB_LSB];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nib1 <= `PWMDAC_NIB_RST;
        end else if (wr_lane0 && aw_idx == `PWMDAC_IDX_NIB1) begin
            nib1 <= w_data[`PWMDAC_NIB_MSB:`PWMDAC_NIB_LSB];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nib2 <= `PWMDAC_NIB_RST;
        end else if (wr_lane0 && aw_idx == `PWMDAC_IDX_NIB2) begin
            nib2 <= w_data[`PWMDAC_NIB_MSB:`PWMDAC_NIB_LSB];
        end
    end

    // only bits 1:0 of the top register reach the code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            staged <= `PWMDAC_CODE_RST;
        end else if (commit) begin
            staged <= {w_data[`PWMDAC_TOP_MSB:0],
                       nib2, nib1, nib0};
        end
    end

    // a commit in the cycle the modulator takes the old code wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending <= 1'b0;
        end else if (commit) begin
            pending <= 1'b1;
        end else if (cif.taken) begin
            pending <= 1'b0;
        end
    end

    assign cif.code    = staged;
    assign cif.pending = pending;

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    logic         rd_mapped;
    logic         rd_status;
    pwmdac_data_t status_word;

    assign arready   = !rvalid;
    assign rd_status = (araddr[7:2] == `PWMDAC_IDX_STATUS);

    always_comb begin
        unique case (araddr[7:2])
            `PWMDAC_IDX_NIB0,
            `PWMDAC_IDX_NIB1,
            `PWMDAC_IDX_NIB2,
            `PWMDAC_IDX_TOP,
            `PWMDAC_IDX_STATUS: rd_mapped = 1'b1;
            default:            rd_mapped = 1'b0;
        endcase
    end

    always_comb begin
        status_word = `PWMDAC_RDATA_RST;
        status_word[`PWMDAC_STAT_ACTIVE]  = cif.active;
        status_word[`PWMDAC_STAT_PENDING] = pending;
        status_word[`PWMDAC_STAT_LEVEL]   = cif.level;
    end

    // data registers are write-only and read back as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= `PWMDAC_RDATA_RST;
            rresp  <= PWMDAC_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_status ? status_word : `PWMDAC_RDATA_RST;
            rresp  <= rd_mapped ? PWMDAC_OKAY : PWMDAC_DECERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // modulator
    // ----------------------------------------------------------------
    pwmdac_mod #(
        .HALF_DIV (HALF_DIV)
    ) u_mod (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .cif      (cif.mod),
        .pin      (shared_port_modulator_output_pin)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    lower_no_commit_a: assert property (
        (wr_lane0 && aw_idx != `PWMDAC_IDX_TOP) |=>
            $stable(staged))
        else $error("lower register write changed the staged code");
    commit_code_a: assert property (
        commit |=> pending && staged == {$past(w_data[1:0]),
                   $past(nib2), $past(nib1), $past(nib0)})
        else $error("commit did not stage the assembled code");
    low_nibble_a: assert property (
        (wr_lane0 && aw_idx == `PWMDAC_IDX_NIB0) |=>
            nib0 == $past(w_data[3:0]))
        else $error("first register did not take code bits 3:0");
    wo_read_zero_a: assert property (
        (arvalid && arready && !rd_status) |=>
            rvalid && rdata == 32'h0000_0000)
        else $error("write-only register read returned data");
    write_answer_a: assert property (
        (aw_held && w_held && !bvalid) |=> bvalid && !aw_held && !w_held)
        else $error("write response not given after both channels");
    unmapped_resp_a: assert property (
        (arvalid && arready && !rd_mapped) |=> rresp == PWMDAC_DECERR)
        else $error("unmapped read not answered with decode error");
    pending_hold_a: assert property (
        (pending && !cif.taken && !commit) |=> pending)
        else $error("pending code lost before the frame boundary");

    commit_c: cover property (commit);
    commit_taken_c: cover property (commit && cif.taken);
    status_read_c: cover property (arvalid && arready && rd_status);
endmodule
`default_nettype wire

// ### test/pwmdac_filter_model.sv
`default_nettype none
module pwmdac_filter_model #(
    parameter int unsigned FRAME = 16384
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        pin,
    output var  logic        frame_done,
    output var  logic [31:0] low_count,
    output var  logic [31:0] fall_count
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // low-time integrator, window aligned to the first falling edge
    // ------------------------------------------------------------
    logic        run;
    logic        prev;
    logic [31:0] cnt;
    logic [31:0] acc;
    logic [31:0] nf;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run        <= 1'b0;
            prev       <= 1'b1;
            cnt        <= '0;
            acc        <= '0;
            nf         <= '0;
            frame_done <= 1'b0;
            low_count  <= '0;
            fall_count <= '0;
        end else begin
            frame_done <= 1'b0;
            prev       <= pin;
            if (!run && !pin) begin
                run <= 1'b1;
                cnt <= 32'h0000_0001;
                acc <= 32'h0000_0001;
                nf  <= 32'h0000_0001;
            end else if (run && cnt == FRAME) begin
                frame_done <= 1'b1;
                low_count  <= acc;
                fall_count <= nf;
                cnt        <= 32'h0000_0001;
                acc        <= {31'h0, !pin};
                nf         <= {31'h0, prev && !pin};
            end else if (run) begin
                cnt <= cnt + 1;
                acc <= acc + {31'h0, !pin};
                nf  <= nf + {31'h0, prev && !pin};
            end
        end
    end
endmodule
`default_nettype wire

// ### test/tb.sv
`include "pwmdac_map.svh"
`default_nettype none
module tb;
    import pwmdac_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned HALF = 1;

    logic         aclk;
    logic         aresetn;
    pwmdac_addr_t awaddr;
    logic         awvalid;
    logic         awready;
    pwmdac_data_t wdata;
    pwmdac_strb_t wstrb;
    logic         wvalid;
    logic         wready;
    pwmdac_resp_t bresp;
    logic         bvalid;
    logic         bready;
    pwmdac_addr_t araddr;
    logic         arvalid;
    logic         arready;
    pwmdac_data_t rdata;
    pwmdac_resp_t rresp;
    logic         rvalid;
    logic         rready;
    logic         pin;
    logic         frame_done;
    logic [31:0]  low_count;
    logic [31:0]  fall_count;
    int           num_errors;
    int           num_checks;

    pwmdac_top #(.HALF_DIV(HALF), .ADDR_W(8)) u_pwmdac_top (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .shared_port_modulator_output_pin(pin)
    );

    pwmdac_filter_model #(.FRAME(16384 * HALF)) u_pwmdac_filter_model (
        .aclk(aclk), .aresetn(aresetn), .pin(pin),
        .frame_done(frame_done), .low_count(low_count),
        .fall_count(fall_count)
    );

    // ------------------------------------------------------------
    // clock, shared tasks
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    function automatic pwmdac_addr_t badr(input logic [5:0] idx);
        return {idx, 2'b00};
    endfunction

    task automatic axi_write(input pwmdac_addr_t a, input pwmdac_data_t d,
                             input pwmdac_resp_t er);
        int n;
        logic got;
        n = 0;
        got = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!got && n < 100) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) got = 1'b1;
        end
        bready <= 1'b0;
        check({31'h0, got}, 32'h0000_0001);
        check({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic axi_read(input pwmdac_addr_t a, input pwmdac_data_t ed,
                            input pwmdac_resp_t er);
        int n;
        logic got;
        n = 0;
        got = 1'b0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!got && n < 100) begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                got = 1'b1;
                check({30'h0, rresp}, {30'h0, er});
                if (er === 2'h0) check(rdata, ed);
            end
        end
        rready <= 1'b0;
        check({31'h0, got}, 32'h0000_0001);
    endtask

    task automatic wait_frame(input logic [31:0] exp_low);
        int n;
        n = 0;
        while (!frame_done && n < 20000) begin
            @(posedge aclk);
            n++;
        end
        check({31'h0, frame_done}, 32'h0000_0001);
        check(low_count, exp_low);
        check(fall_count, 32'h0000_0040);
        @(posedge aclk);
    endtask

    task automatic load_low(input logic [13:0] c);
        axi_write(badr(`PWMDAC_IDX_NIB0), {28'h0, c[3:0]}, 2'h0);
        axi_write(badr(`PWMDAC_IDX_NIB1), {28'h0, c[7:4]}, 2'h0);
        axi_write(badr(`PWMDAC_IDX_NIB2), {28'h0, c[11:8]}, 2'h0);
    endtask

    // ------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (95000) @(posedge aclk);
        num_errors++;
        conclude();
    end

    initial begin
        num_errors = 0;
        num_checks = 0;
        aresetn = 1'b0;
        awaddr = '0;
        awvalid = 1'b0;
        wdata = '0;
        wstrb = '0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = '0;
        arvalid = 1'b0;
        rready = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        // unmapped place and a write-only data register
        axi_read(badr(6'h00), 32'h0000_0000, 2'h3);
        axi_write(badr(6'h00), 32'h0000_000f, 2'h3);
        axi_read(badr(`PWMDAC_IDX_NIB1), 32'h0000_0000, 2'h0);
        // staging alone leaves the idle output high
        load_low(14'h2a5c);
        repeat (300) @(posedge aclk);
        check({31'h0, pin}, 32'h0000_0001);
        // status: idle, nothing pending, pin high; writes leave it alone
        axi_write(badr(`PWMDAC_IDX_STATUS), 32'h0000_0003, 2'h0);
        axi_read(badr(`PWMDAC_IDX_STATUS), 32'h0000_0004, 2'h0);
        // top write 4'h6: bits 3:2 must not reach the code
        axi_write(badr(`PWMDAC_IDX_TOP), 32'h0000_0006, 2'h0);
        wait_frame(32'h0000_2a5c + 32'h0000_0040);
        // stage a new code without commit: output unchanged
        load_low(14'h0123);
        wait_frame(32'h0000_2a5c + 32'h0000_0040);
        // commit mid-frame: current frame keeps the old duty
        repeat (2000) @(posedge aclk);
        axi_write(badr(`PWMDAC_IDX_TOP), 32'h0000_000c, 2'h0);
        wait_frame(32'h0000_2a5c + 32'h0000_0040);
        wait_frame(32'h0000_0123 + 32'h0000_0040);
        conclude();
    end
endmodule
`default_nettype wire
